/* File: pll_synth.v */
// divider, modulus control and phase detector logic of the three synthesizer loops
`timescale 1ns/1ns
`include "pll_synth_regs.vh"

// ****************************************************************
// one loop: pin synchroniser, swallow and main counter, detector
// ****************************************************************
module synth_loop #(
  parameter N_W = 13,                               // main counter width
  parameter A_W = 7                                 // swallow counter width
) (
  input  wire           clk_i,                      // reference clock
  input  wire           rst_i,                      // synchronous reset, active high
  input  wire           vco_i,                      // prescaled or direct vco pin
  input  wire           ref_tick_i,                 // loop reference pulse
  input  wire [N_W-1:0] main_i,                     // main count
  input  wire [A_W-1:0] swallow_i,                  // swallow count
  input  wire           pol_i,                      // detector polarity
  output reg            mod_hi_o,                   // high modulus request
  output reg            src_o,                      // pump sources current
  output reg            snk_o                       // pump sinks current
);

  reg           sync1;
  reg           sync2;
  reg           sync3;
  reg           level;
  reg [N_W-1:0] main_cnt;
  reg [A_W-1:0] sw_cnt;
  reg           div_tick;
  reg           up_flag;
  reg           dn_flag;
  wire          vco_edge;

  // three flops on the pin; only the agreeing second and third stages are looked at
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      level <= 1'b0;
    end else begin
      sync1 <= vco_i;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        level <= sync3;
      end
    end
  end

  // a rising edge counts once the filtered level goes high
  assign vco_edge = (sync2 == sync3) && sync3 && !level;

  // swallow first at the high modulus, then the rest of the main count low
  always @(posedge clk_i) begin
    if (rst_i) begin
      main_cnt <= {N_W{1'b0}};
      sw_cnt   <= {A_W{1'b0}};
      mod_hi_o <= 1'b0;
      div_tick <= 1'b0;
    end else begin
      div_tick <= 1'b0;
      if (vco_edge) begin
        if (main_cnt <= {{(N_W-1){1'b0}}, 1'b1}) begin
          main_cnt <= main_i;
          sw_cnt   <= swallow_i;
          mod_hi_o <= (swallow_i != {A_W{1'b0}});
          div_tick <= 1'b1;
        end else begin
          main_cnt <= main_cnt - {{(N_W-1){1'b0}}, 1'b1};
          if (sw_cnt != {A_W{1'b0}}) begin
            sw_cnt <= sw_cnt - {{(A_W-1){1'b0}}, 1'b1};
          end
          mod_hi_o <= (sw_cnt > {{(A_W-1){1'b0}}, 1'b1});
        end
      end
    end
  end

  // phase-frequency detector: reference leads sets up, divider leads sets down
  always @(posedge clk_i) begin
    if (rst_i) begin
      up_flag <= 1'b0;
      dn_flag <= 1'b0;
    end else begin
      if ((up_flag || ref_tick_i) && (dn_flag || div_tick)) begin
        up_flag <= 1'b0;
        dn_flag <= 1'b0;
      end else begin
        up_flag <= up_flag || ref_tick_i;
        dn_flag <= dn_flag || div_tick;
      end
    end
  end

  // pump drive, swapped for an inverting filter and vco pair
  always @(posedge clk_i) begin
    if (rst_i) begin
      src_o <= 1'b0;
      snk_o <= 1'b0;
    end else begin
      src_o <= pol_i ? dn_flag : up_flag;
      snk_o <= pol_i ? up_flag : dn_flag;
    end
  end

endmodule // synth_loop

module pll_synth (
  input  wire                  clk_i,               // reference oscillator clock
  input  wire                  rst_i,               // synchronous reset, active high
  input  wire                  cyc_i,               // wishbone cycle
  input  wire                  stb_i,               // wishbone strobe
  input  wire                  we_i,                // wishbone write enable
  input  wire [`ADDR_W-1:0]    adr_i,               // wishbone byte address
  input  wire [3:0]            sel_i,               // wishbone byte enables
  input  wire [31:0]           dat_i,               // wishbone write data
  output reg  [31:0]           dat_o,               // wishbone read data
  output reg                   ack_o,               // wishbone acknowledge
  input  wire                  tx_vco_i,            // transmit prescaler output pin
  input  wire                  rx_vco_i,            // receive prescaler output pin
  input  wire                  lo2_vco_i,           // second oscillator vco pin
  output reg                   tx_mod_o,            // transmit modulus control level
  output reg                   tx_mod_oe_o,         // transmit modulus control enable
  output reg                   rx_mod_o,            // receive modulus control level
  output reg                   rx_mod_oe_o,         // receive modulus control enable
  output reg                   mod_volt_o,          // modulus drive style, 1 voltage
  output reg                   tx_cp_o,             // transmit pump level, 1 source
  output reg                   tx_cp_oe_o,          // transmit pump enable
  output reg                   tx_cp_high_o,        // transmit pump high current
  output reg                   rx_cp_o,             // receive pump level, 1 source
  output reg                   rx_cp_oe_o,          // receive pump enable
  output reg                   rx_cp_high_o,        // receive pump high current
  output reg                   lo2_cp_o,            // second loop pump level
  output reg                   lo2_cp_oe_o,         // second loop pump enable
  output reg                   lo2_cp_high_o,       // second loop pump high current
  output reg [`CAP_SEL_W-1:0]  cap_sel_o            // tank capacitor select code
);

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  reg  [31:0]            tx_config;
  reg  [31:0]            rx_config;
  reg  [31:0]            lo2_config;
  reg  [31:0]            ref_config;
  reg  [`REF_DIV_W-1:0]  ref_cnt;
  reg                    ref_tick;
  reg  [31:0]            next_rdata;
  wire                   access;
  wire                   tx_mod_hi;
  wire                   tx_src;
  wire                   tx_snk;
  wire                   rx_mod_hi;
  wire                   rx_src;
  wire                   rx_snk;
  wire                   lo2_src;
  wire                   lo2_snk;

  // one access per strobe; ack falls the cycle after it rose
  assign access = cyc_i && stb_i && !ack_o;

  // byte-lane merge of write data into a register word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wdata;
    input [3:0]  lanes;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (lanes[i]) begin
          merge[i*8 +: 8] = wdata[i*8 +: 8];
        end
      end
    end
  endfunction

  // ****************************************************************
  // wishbone slave
  // ****************************************************************

  // writes land on the acknowledged edge; unmapped addresses ack and drop data
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_config  <= `RST_WORD;
      rx_config  <= `RST_WORD;
      lo2_config <= `RST_WORD;
      ref_config <= {{(32-`REF_DIV_W){1'b0}}, `RST_REF_DIV};
      ack_o      <= 1'b0;
      dat_o      <= `RST_WORD;
    end else begin
      ack_o <= access;
      dat_o <= access ? next_rdata : `RST_WORD;
      if (access && we_i) begin
        case (adr_i)
          `OFS_TX_CONFIG:  tx_config  <= merge(tx_config, dat_i, sel_i);
          `OFS_RX_CONFIG:  rx_config  <= merge(rx_config, dat_i, sel_i);
          `OFS_LO2_CONFIG: lo2_config <= merge(lo2_config, dat_i, sel_i);
          `OFS_REF_CONFIG: ref_config <= merge(ref_config, dat_i, sel_i);
          default: begin
          end
        endcase
      end
    end
  end

  // read back the fields; reserved bits read zero, loop words carry live pump and tx/rx modulus state in bits 31 to 29
  always @* begin
    next_rdata = `RST_WORD;
    case (adr_i)
      `OFS_TX_CONFIG: begin
        next_rdata[`MAIN_POL_BIT:0] = tx_config[`MAIN_POL_BIT:0];
        next_rdata[31]              = tx_src;
        next_rdata[30]              = tx_snk;
        next_rdata[29]              = tx_mod_hi;
      end
      `OFS_RX_CONFIG: begin
        next_rdata[`MAIN_POL_BIT:0] = rx_config[`MAIN_POL_BIT:0];
        next_rdata[31]              = rx_src;
        next_rdata[30]              = rx_snk;
        next_rdata[29]              = rx_mod_hi;
      end
      `OFS_LO2_CONFIG: begin
        next_rdata[`MOD_VOLT_BIT:0] = lo2_config[`MOD_VOLT_BIT:0];
        next_rdata[31]              = lo2_src;
        next_rdata[30]              = lo2_snk;
      end
      `OFS_REF_CONFIG: begin
        next_rdata[`REF_DIV_MSB:`REF_DIV_LSB] = ref_config[`REF_DIV_MSB:`REF_DIV_LSB];
        next_rdata[`CAP_SEL_MSB:`CAP_SEL_LSB] = ref_config[`CAP_SEL_MSB:`CAP_SEL_LSB];
      end
      default: next_rdata = `RST_WORD;
    endcase
  end

  // ****************************************************************
  // shared reference divider
  // ****************************************************************

  // one pulse per divide count; a count of zero or one gives every cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ref_cnt  <= {`REF_DIV_W{1'b0}};
      ref_tick <= 1'b0;
    end else begin
      if (ref_cnt <= {{(`REF_DIV_W-1){1'b0}}, 1'b1}) begin
        ref_cnt  <= ref_config[`REF_DIV_MSB:`REF_DIV_LSB];
        ref_tick <= 1'b1;
      end else begin
        ref_cnt  <= ref_cnt - {{(`REF_DIV_W-1){1'b0}}, 1'b1};
        ref_tick <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // the three loops
  // ****************************************************************

  // transmit and receive share no state beyond the reference pulse
  synth_loop #(
    .N_W (`MAIN_W),
    .A_W (`SWALLOW_W)
  ) u_tx_loop (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .vco_i      (tx_vco_i),
    .ref_tick_i (ref_tick),
    .main_i     (tx_config[`MAIN_MSB:`MAIN_LSB]),
    .swallow_i  (tx_config[`SWALLOW_MSB:`SWALLOW_LSB]),
    .pol_i      (tx_config[`MAIN_POL_BIT]),
    .mod_hi_o   (tx_mod_hi),
    .src_o      (tx_src),
    .snk_o      (tx_snk)
  );

  synth_loop #(
    .N_W (`MAIN_W),
    .A_W (`SWALLOW_W)
  ) u_rx_loop (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .vco_i      (rx_vco_i),
    .ref_tick_i (ref_tick),
    .main_i     (rx_config[`MAIN_MSB:`MAIN_LSB]),
    .swallow_i  (rx_config[`SWALLOW_MSB:`SWALLOW_LSB]),
    .pol_i      (rx_config[`MAIN_POL_BIT]),
    .mod_hi_o   (rx_mod_hi),
    .src_o      (rx_src),
    .snk_o      (rx_snk)
  );

  // second oscillator has no prescaler, so the swallow stage is held at zero
  synth_loop #(
    .N_W (`LO2_CNT_W),
    .A_W (`SWALLOW_W)
  ) u_lo2_loop (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .vco_i      (lo2_vco_i),
    .ref_tick_i (ref_tick),
    .main_i     (lo2_config[`LO2_CNT_MSB:`LO2_CNT_LSB]),
    .swallow_i  ({`SWALLOW_W{1'b0}}),
    .pol_i      (lo2_config[`LO2_POL_BIT]),
    .mod_hi_o   (),
    .src_o      (lo2_src),
    .snk_o      (lo2_snk)
  );

  // ****************************************************************
  // pin drive
  // ****************************************************************

  // pumps float unless exactly one of source or sink is asked for;
  // current mode only drives while requesting the high modulus
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_mod_o      <= 1'b0;
      tx_mod_oe_o   <= 1'b0;
      rx_mod_o      <= 1'b0;
      rx_mod_oe_o   <= 1'b0;
      mod_volt_o    <= 1'b0;
      tx_cp_o       <= 1'b0;
      tx_cp_oe_o    <= 1'b0;
      tx_cp_high_o  <= 1'b0;
      rx_cp_o       <= 1'b0;
      rx_cp_oe_o    <= 1'b0;
      rx_cp_high_o  <= 1'b0;
      lo2_cp_o      <= 1'b0;
      lo2_cp_oe_o   <= 1'b0;
      lo2_cp_high_o <= 1'b0;
      cap_sel_o     <= {`CAP_SEL_W{1'b0}};
    end else begin
      mod_volt_o    <= lo2_config[`MOD_VOLT_BIT];
      tx_mod_o      <= tx_mod_hi;
      tx_mod_oe_o   <= lo2_config[`MOD_VOLT_BIT] || tx_mod_hi;
      rx_mod_o      <= rx_mod_hi;
      rx_mod_oe_o   <= lo2_config[`MOD_VOLT_BIT] || rx_mod_hi;
      tx_cp_o       <= tx_src;
      tx_cp_oe_o    <= tx_src ^ tx_snk;
      tx_cp_high_o  <= tx_config[`MAIN_GAIN_BIT];
      rx_cp_o       <= rx_src;
      rx_cp_oe_o    <= rx_src ^ rx_snk;
      rx_cp_high_o  <= rx_config[`MAIN_GAIN_BIT];
      lo2_cp_o      <= lo2_src;
      lo2_cp_oe_o   <= lo2_src ^ lo2_snk;
      lo2_cp_high_o <= lo2_config[`LO2_GAIN_BIT];
      cap_sel_o     <= ref_config[`CAP_SEL_MSB:`CAP_SEL_LSB];
    end
  end

endmodule // pll_synth

/* File: pll_synth_chk.sv */
// concurrent checks on the synthesizer divider block ports
`timescale 1ns/1ns
`include "pll_synth_regs.vh"
// ****************************************************************
// checker
// ****************************************************************
module pll_synth_chk (
  input wire logic                 clk_i,         // clock
  input wire logic                 rst_i,         // reset
  input wire logic                 cyc_i,         // cycle
  input wire logic                 stb_i,         // strobe
  input wire logic                 ack_o,         // acknowledge
  input wire logic [31:0]          dat_o,         // read data
  input wire logic                 tx_mod_o,      // tx modulus
  input wire logic                 tx_mod_oe_o,   // tx modulus enable
  input wire logic                 rx_mod_o,      // rx modulus
  input wire logic                 rx_mod_oe_o,   // rx modulus enable
  input wire logic                 mod_volt_o,    // drive style
  input wire logic                 tx_cp_oe_o,    // tx pump enable
  input wire logic                 tx_cp_high_o,  // tx pump current
  input wire logic                 rx_cp_high_o,  // rx pump current
  input wire logic                 lo2_cp_high_o, // lo2 pump current
  input wire logic [`CAP_SEL_W-1:0] cap_sel_o     // tank code
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus handshake and outputs after reset
  a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
  a_ack_has_req: assert property ($rose(ack_o) |-> $past(cyc_i) && $past(stb_i)) else $error("ack unasked");
  a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
  a_reset_quiet: assert property ($past(rst_i) |-> !ack_o && !tx_cp_oe_o && !tx_mod_oe_o && cap_sel_o == 3'h0)
    else $error("outputs not cleared");
  // modulus drive style, both main loops
  a_volt_drive: assert property (mod_volt_o [*3] |-> tx_mod_oe_o && rx_mod_oe_o)
    else $error("voltage mode not driving");
  a_cur_drive: assert property (!mod_volt_o [*3] |-> tx_mod_oe_o == tx_mod_o && rx_mod_oe_o == rx_mod_o)
    else $error("current mode drive wrong");
  // settings only move after a bus write
  a_cfg_on_write: assert property ($changed({tx_cp_high_o, rx_cp_high_o, lo2_cp_high_o, cap_sel_o})
    |-> $past(ack_o) || $past(ack_o, 2)) else $error("setting moved without write");
endmodule // pll_synth_chk

bind pll_synth pll_synth_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .dat_o(dat_o), .tx_mod_o(tx_mod_o), .tx_mod_oe_o(tx_mod_oe_o), .rx_mod_o(rx_mod_o), .rx_mod_oe_o(rx_mod_oe_o),
  .mod_volt_o(mod_volt_o), .tx_cp_oe_o(tx_cp_oe_o), .tx_cp_high_o(tx_cp_high_o), .rx_cp_high_o(rx_cp_high_o),
  .lo2_cp_high_o(lo2_cp_high_o), .cap_sel_o(cap_sel_o));

/* File: pll_synth_dividers_test.sv */
// self-checking bench for the synthesizer divider block
`timescale 1ns/1ns
`include "pll_synth_regs.vh"
// ****************************************************************
// bench
// ****************************************************************
module pll_synthesizer_dividers_test;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ps_en = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, dat_o;
  logic ack_o, tx_vco, rx_vco, lo2_vco, tx_mod_o, tx_mod_oe_o, rx_mod_o, rx_mod_oe_o, mod_volt_o;
  logic tx_cp_o, tx_cp_oe_o, tx_cp_high_o, rx_cp_o, rx_cp_oe_o, rx_cp_high_o, lo2_cp_o, lo2_cp_oe_o, lo2_cp_high_o;
  logic [2:0] cap_sel_o;
  integer errors = 0, checked = 0, g;
  always #5 clk_i = ~clk_i;
  pll_synth u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .tx_vco_i(tx_vco), .rx_vco_i(rx_vco), .lo2_vco_i(lo2_vco),
    .tx_mod_o(tx_mod_o), .tx_mod_oe_o(tx_mod_oe_o), .rx_mod_o(rx_mod_o), .rx_mod_oe_o(rx_mod_oe_o),
    .mod_volt_o(mod_volt_o), .tx_cp_o(tx_cp_o), .tx_cp_oe_o(tx_cp_oe_o), .tx_cp_high_o(tx_cp_high_o),
    .rx_cp_o(rx_cp_o), .rx_cp_oe_o(rx_cp_oe_o), .rx_cp_high_o(rx_cp_high_o), .lo2_cp_o(lo2_cp_o),
    .lo2_cp_oe_o(lo2_cp_oe_o), .lo2_cp_high_o(lo2_cp_high_o), .cap_sel_o(cap_sel_o));
  prescaler_model u_ps_tx (.clk_i(clk_i), .en_i(ps_en), .mod_i(tx_mod_o), .out_o(tx_vco));
  prescaler_model u_ps_rx (.clk_i(clk_i), .en_i(ps_en), .mod_i(rx_mod_o), .out_o(rx_vco));
  prescaler_model u_ps_lo2 (.clk_i(clk_i), .en_i(ps_en), .mod_i(1'b0), .out_o(lo2_vco));

  task summarize;
    begin
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
    end
  endtask
  // one classic cycle; request held until ack is sampled high
  task wb_io(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
    integer n;
    begin
      n = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 50) begin
        @(posedge clk_i);
        n = n + 1;
      end
      q = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (n >= 50) begin
        errors = errors + 1;
        $display("BAD %0t bus wait ran out", $time);
        summarize;
      end
      @(posedge clk_i);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    begin
      wb_io(1'b1, a, d, s, q);
    end
  endtask
  task rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
    logic [31:0] q;
    begin
      wb_io(1'b0, a, 32'h0, 4'hf, q);
      chk(q & m, e, what);
    end
  endtask
  function logic [31:0] cfg(input logic [12:0] n, input logic [6:0] a, input logic gn, input logic p);
    cfg = {10'h0, p, gn, n, a};
  endfunction
  // counts prescaler edges seen while high modulus is asked over two whole loop cycles
  task mod_count(input logic which, input integer n, input integer exp);
    integer i, hits, edges;
    logic prev, p;
    begin
      i = 0; hits = 0; edges = 0; prev = 1'b1;
      while (i < 5000 && edges < 2 * n) begin
        @(posedge clk_i);
        i = i + 1;
        p = which ? rx_vco : tx_vco;
        if (p && !prev) begin
          edges = edges + 1;
          hits = hits + (which ? rx_mod_o : tx_mod_o);
        end
        prev = p;
      end
      if (i >= 5000) begin
        errors = errors + 1;
        $display("BAD %0t prescaler edge wait ran out", $time);
        summarize;
      end
      chk(hits, exp, "high modulus edges");
    end
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(4'h0, 32'h003fffff, 32'h0, "tx reset");
    rd_chk(4'h4, 32'h003fffff, 32'h0, "rx reset");
    rd_chk(4'h8, 32'h0001ffff, 32'h0, "lo2 reset");
    rd_chk(4'hc, 32'h001c0fff, 32'h1, "ref reset");
    $display("test reset values done");
    wr(4'h0, 32'hffffffff, 4'h1);
    rd_chk(4'h0, 32'h1fffffff, 32'h000000ff, "one lane");
    wr(4'h0, 32'hffffffff, 4'hf);
    rd_chk(4'h0, 32'h1fffffff, 32'h003fffff, "tx full");
    wr(4'h2, 32'h0, 4'hf);
    rd_chk(4'h0, 32'h1fffffff, 32'h003fffff, "tx kept");
    rd_chk(4'h2, 32'hffffffff, 32'h0, "unmapped");
    $display("test lanes done");
    // opposite gains on tx and rx show the loops are set apart
    for (g = 0; g < 2; g = g + 1) begin
      wr(4'h0, cfg(13'h8, 7'h3, g[0], 1'b0), 4'hf);
      wr(4'h4, cfg(13'ha, 7'h6, !g[0], 1'b0), 4'hf);
      wr(4'h8, {15'h0, g[0], 1'b0, g[0], 14'h10}, 4'hf);
      repeat (3) @(posedge clk_i);
      chk(tx_cp_high_o, g[0], "tx gain");
      chk(rx_cp_high_o, !g[0], "rx gain");
      chk(lo2_cp_high_o, g[0], "lo2 gain");
      chk(mod_volt_o, g[0], "drive style");
    end
    $display("test gains done");
    // vco stopped: only reference pulses arrive, pump must keep pushing
    for (g = 0; g < 2; g = g + 1) begin
      wr(4'hc, 32'h00000004, 4'hf);
      wr(4'h0, cfg(13'h8, 7'h3, 1'b0, g[0]), 4'hf);
      wr(4'h4, cfg(13'h8, 7'h3, 1'b0, g[0]), 4'hf);
      wr(4'h8, {16'h0, g[0], 1'b0, 14'h10}, 4'hf);
      repeat (20) @(posedge clk_i);
      chk({tx_cp_oe_o, tx_cp_o}, {1'b1, !g[0]}, "tx pump");
      chk({rx_cp_oe_o, rx_cp_o}, {1'b1, !g[0]}, "rx pump");
      chk({lo2_cp_oe_o, lo2_cp_o}, {1'b1, !g[0]}, "lo2 pump");
    end
    $display("test polarity done");
    for (g = 0; g < 8; g = g + 1) begin
      wr(4'hc, {11'h0, g[2:0], 6'h0, 12'h4}, 4'hf);
      repeat (3) @(posedge clk_i);
      chk(cap_sel_o, g[2:0], "tank code");
    end
    $display("test tank done");
    ps_en <= 1'b1;
    // ratios split as total over low modulus, remainder into the swallow count
    wr(4'h0, cfg(13'h8, 7'h3, 1'b0, 1'b0), 4'hf);
    wr(4'h4, cfg(13'ha, 7'h6, 1'b0, 1'b0), 4'hf);
    repeat (200) @(posedge clk_i);
    mod_count(1'b0, 8, 6);
    mod_count(1'b1, 10, 12);
    wr(4'h0, cfg(13'h4, 7'h5, 1'b0, 1'b0), 4'hf);
    wr(4'h4, cfg(13'h6, 7'h0, 1'b0, 1'b0), 4'hf);
    repeat (200) @(posedge clk_i);
    mod_count(1'b0, 4, 8);
    mod_count(1'b1, 6, 0);
    $display("test modulus done");
    summarize;
  end
endmodule // pll_synthesizer_dividers_test

/* File: pll_synth_regs.vh */
// register offsets, field positions and reset values of the synthesizer divider block
`ifndef PLL_SYNTH_REGS_VH
`define PLL_SYNTH_REGS_VH

// ****************************************************************
// word offsets, byte addresses on the bus
// ****************************************************************
`define ADDR_W            4
`define OFS_TX_CONFIG     4'h0
`define OFS_RX_CONFIG     4'h4
`define OFS_LO2_CONFIG    4'h8
`define OFS_REF_CONFIG    4'hc

// ****************************************************************
// transmit and receive loop configuration words
// ****************************************************************
`define SWALLOW_LSB       0
`define SWALLOW_MSB       6
`define SWALLOW_W         7
`define MAIN_LSB          7
`define MAIN_MSB          19
`define MAIN_W            13
`define MAIN_GAIN_BIT     20
`define MAIN_POL_BIT      21

// ****************************************************************
// second local oscillator loop configuration word
// ****************************************************************
`define LO2_CNT_LSB       0
`define LO2_CNT_MSB       13
`define LO2_CNT_W         14
`define LO2_GAIN_BIT      14
`define LO2_POL_BIT       15
`define MOD_VOLT_BIT      16

// ****************************************************************
// reference divider and tank capacitor word
// ****************************************************************
`define REF_DIV_LSB       0
`define REF_DIV_MSB       11
`define REF_DIV_W         12
`define CAP_SEL_LSB       18
`define CAP_SEL_MSB       20
`define CAP_SEL_W         3

// ****************************************************************
// reset values
// ****************************************************************
`define RST_WORD          32'h0000_0000
`define RST_REF_DIV       12'h001

`endif

/* File: prescaler_model.sv */
// behavioural dual-modulus prescaler fed by a free-running vco
`timescale 1ns/1ns
// ****************************************************************
// prescaler: divides by 8 or 9 clocks per output cycle
// ****************************************************************
module prescaler_model (
  input  wire logic clk_i,  // reference clock, used as vco timebase
  input  wire logic en_i,   // vco running
  input  wire logic mod_i,  // high modulus request
  output logic      out_o   // prescaled output pin
);
  logic [3:0] cnt;
  initial begin
    cnt   = 4'h0;
    out_o = 1'b0;
  end
  // modulus sampled every clock so a late request still stretches the cycle
  always @(posedge clk_i) begin
    if (!en_i) begin
      cnt   <= 4'h0;
      out_o <= 1'b0;
    end else begin
      cnt   <= (cnt >= (mod_i ? 4'h8 : 4'h7)) ? 4'h0 : cnt + 4'h1;
      out_o <= (cnt >= (mod_i ? 4'h8 : 4'h7)) || (cnt < 4'h3);   // high 4 clocks, slow enough for the pin
    end
  end
endmodule // prescaler_model
